// *** sim/sdl_host_model.sv ***
`timescale 1ns/1ns
module sdl_host_model (
  // link pins toward the device
  output logic link_clk_o,
  output logic select_n_o,
  output logic serial_in_o
);
  initial
  begin
    link_clk_o = 1'b0;
    select_n_o = 1'b1;
    serial_in_o = 1'b0;
  end
  // clock stands low between frames; by_sel shifts on select rises
  task automatic send(input logic [11:0] w, input logic by_sel);
    #3;
    if (!by_sel)
      select_n_o = 1'b0;
    for (int i = 11; i >= 0; i--)
    begin
      if (by_sel)
        select_n_o = 1'b0;
      serial_in_o = w[i];
      #80;
      if (by_sel)
        select_n_o = 1'b1;
      else
        link_clk_o = 1'b1;
      #40;
      // deselect while clock high, so no false extra shift
      if (!by_sel && i == 0)
        select_n_o = 1'b1;
      #40;
      link_clk_o = 1'b0;
    end
    serial_in_o = ~w[0];
  endtask : send
endmodule : sdl_host_model

// *** sim/sdl_load_logic_properties.sv ***
`timescale 1ns/1ns
module sdl_load_logic_chk (
  // watched ports
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire logic load_strobe_n_i,
  input wire logic zero_clear_n_i,
  input wire logic [11:0] code_o,
  input wire logic [11:0] shift_o
);
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!resetn_i);
  // windows of 8 cover the pin filter latency
  clear_forces_zero_a: assert property (!zero_clear_n_i [*8] |-> code_o == 12'h000)
    else $error("code not zero under clear");
  code_held_a: assert property ((load_strobe_n_i && zero_clear_n_i) [*8] |-> $stable(code_o))
    else $error("code moved while latched");
  load_tracks_a: assert property ((!load_strobe_n_i && zero_clear_n_i && $stable(shift_o)) [*8] |->
    code_o == shift_o) else $error("code not following shift word");
  zeros_latched_a: assert property (!zero_clear_n_i [*6] ##1 (zero_clear_n_i && load_strobe_n_i) [*8]
    |-> code_o == 12'h000) else $error("zeros lost after clear");
  load_copy_a: assert property (($fell(load_strobe_n_i) && zero_clear_n_i) ##1
    (!load_strobe_n_i && zero_clear_n_i && $stable(shift_o)) [*3] ##1 (zero_clear_n_i && $stable(shift_o)) [*3]
    |-> code_o == shift_o) else $error("code not loaded on strobe");
  clear_wins_a: assert property ((!zero_clear_n_i && !load_strobe_n_i) [*8] |-> code_o == 12'h000)
    else $error("load overrode clear");
  cover property ($fell(load_strobe_n_i));
  cover property (!zero_clear_n_i [*8]);
  cover property ($changed(shift_o));
endmodule : sdl_load_logic_chk
bind sdl_load_logic sdl_load_logic_chk CHK (.clk_sys_i, .resetn_i, .load_strobe_n_i, .zero_clear_n_i,
  .code_o, .shift_o);

// *** sim/tb.sv ***
`timescale 1ns/1ns
module tb;
  logic clk_sys_i, resetn_i, load_strobe_n_i, zero_clear_n_i, link_clk_i, select_n_i, serial_in_i;
  logic [11:0] code_o, shift_o;
  logic overflow_o;
  int n_mismatch = 0;
  int samples_checked = 0;
  int cyc = 0;
  sdl_load_logic DUT (.clk_sys_i, .resetn_i, .link_clk_i, .select_n_i, .serial_in_i, .load_strobe_n_i,
    .zero_clear_n_i, .code_o, .shift_o, .overflow_o);
  sdl_host_model HOST (.link_clk_o(link_clk_i), .select_n_o(select_n_i), .serial_in_o(serial_in_i));
  task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic idle(input int n);
    repeat (n) @(negedge clk_sys_i);
  endtask : idle
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : wrap_up
  task automatic t_clock_load;
    HOST.send(12'ha5c, 1'b0);
    idle(14);
    chk(shift_o, 12'ha5c);
    chk(code_o, 12'h000);
    load_strobe_n_i = 1'b0;
    idle(4);
    load_strobe_n_i = 1'b1;
    idle(12);
    chk(code_o, 12'ha5c);
    chk(shift_o, 12'ha5c);
    $display("t_clock_load done");
  endtask : t_clock_load
  task automatic t_select_hold;
    HOST.send(12'h3e1, 1'b1);
    idle(14);
    chk(shift_o, 12'h3e1);
    chk(code_o, 12'ha5c);
    load_strobe_n_i = 1'b0;
    idle(10);
    chk(code_o, 12'h3e1);
    load_strobe_n_i = 1'b1;
    idle(12);
    chk(code_o, 12'h3e1);
    $display("t_select_hold done");
  endtask : t_select_hold
  task automatic t_clear_fill;
    zero_clear_n_i = 1'b0;
    idle(8);
    chk(code_o, 12'h000);
    // clear stalls the buffer: 16 in store plus one in its read register, the 18th is lost
    for (int i = 0; i < 18; i++)
      HOST.send(12'h100 + i[11:0], 1'b0);
    idle(1);
    chk({11'h000, overflow_o}, 12'h001);
    chk(shift_o, 12'h3e1);
    load_strobe_n_i = 1'b0;
    idle(10);
    chk(code_o, 12'h000);
    load_strobe_n_i = 1'b1;
    idle(6);
    zero_clear_n_i = 1'b1;
    idle(300);
    chk(code_o, 12'h000);
    chk(shift_o, 12'h110);
    $display("t_clear_fill done");
  endtask : t_clear_fill
  initial
  begin
    clk_sys_i = 1'b0;
    forever #4 clk_sys_i = ~clk_sys_i;
  end
  always @(posedge clk_sys_i)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_mismatch++;
      wrap_up();
    end
  end
  initial
  begin
    resetn_i = 1'b0;
    load_strobe_n_i = 1'b1;
    zero_clear_n_i = 1'b1;
    idle(4);
    resetn_i = 1'b1;
    idle(8);
    t_clock_load();
    t_select_hold();
    t_clear_fill();
    wrap_up();
  end
endmodule : tb

// *** src/sdl_cfg.svh ***
`ifndef SDL_CFG_SVH
`define SDL_CFG_SVH
// Overview of operation
// - select low, clear and load high: serial clock rising edge shifts one bit, code register held.
// - select and serial clock interchangeable; select rising with clock low also shifts one bit.
// - load falling with select and clear high copies shift register into code register.
// - clear low forces code register to zero; zeros stay latched after clear rises while load is high.
// - data most significant bit first, captured on serial clock rising edges.
// - shift register and code register each hold a 12-bit natural binary word.
`define SDL_CODE_W 12
`define SDL_CODE_RST 12'h000
`define SDL_FIFO_DEPTH 16
`define SDL_SYNC_STAGES 3
`endif

// *** src/sdl_fifo.sv ***
`timescale 1ns/1ns
module sdl_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // fill side
  input wire logic [WIDTH-1:0] wr_data_i,
  input wire logic wr_valid_i,
  output logic wr_ready_o,
  // drain side
  output logic [WIDTH-1:0] rd_data_o,
  output logic rd_valid_o,
  input wire logic rd_ready_i
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW:0] wr_ptr_r;
  logic [AW:0] rd_ptr_r;
  logic full;
  logic empty;
  logic do_wr;

  assign full = (wr_ptr_r[AW] != rd_ptr_r[AW]) && (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]);
  assign empty = (wr_ptr_r == rd_ptr_r);
  assign wr_ready_o = !full;
  assign do_wr = wr_valid_i && !full;

  always_ff @(posedge clk_i)
  begin
    if (do_wr)
      mem_r[wr_ptr_r[AW-1:0]] <= wr_data_i;
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      wr_ptr_r <= '0;
    else if (do_wr)
      wr_ptr_r <= wr_ptr_r + 1'b1;
  end

  // registered read port; output word held until taken
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      rd_ptr_r <= '0;
      rd_valid_o <= 1'b0;
      rd_data_o <= '0;
    end
    else if (!rd_valid_o || rd_ready_i)
    begin
      if (!empty)
      begin
        rd_data_o <= mem_r[rd_ptr_r[AW-1:0]];
        rd_valid_o <= 1'b1;
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
      else
        rd_valid_o <= 1'b0;
    end
  end

endmodule : sdl_fifo

// *** src/sdl_load_logic.sv ***
`timescale 1ns/1ns
`include "sdl_cfg.svh"
module sdl_load_logic (
  // system clock and reset
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  // serial link; shift clock is select-gated link clock
  input wire logic link_clk_i,
  input wire logic select_n_i,
  input wire logic serial_in_i,
  // asynchronous control pins
  input wire logic load_strobe_n_i,
  input wire logic zero_clear_n_i,
  // converter code and status
  output logic [11:0] code_o,
  output logic [11:0] shift_o,
  output logic overflow_o
);
  // ----------------------------------------
  // link domain: shift register
  // ----------------------------------------
  // shift clock is the OR of clock and select, so either rising while the other is low
  // advances one bit; a host that raises select while clock is low risks a false shift
  logic shift_clk;
  assign shift_clk = link_clk_i | select_n_i;
  sdl_pkg::sdl_code_t shift_r;
  logic [3:0] bit_cnt_r;
  logic word_tgl_r;
  sdl_pkg::sdl_code_t word_r;

  // no reset on the shift register: the clear pin leaves it alone
  always_ff @(posedge shift_clk)
  begin
    shift_r <= {shift_r[`SDL_CODE_W-2:0], serial_in_i};
  end

  // ----------------------------------------
  // link domain: word framing
  // ----------------------------------------
  // framing counts edges from reset; with no framing pin a stray edge
  // moves every later word boundary until the next reset
  logic word_end;
  assign word_end = (bit_cnt_r == 4'hb);

  always_ff @(posedge shift_clk or negedge resetn_i)
  begin
    if (!resetn_i)
      bit_cnt_r <= 4'h0;
    else if (word_end)
      bit_cnt_r <= 4'h0;
    else
      bit_cnt_r <= bit_cnt_r + 4'h1;
  end

  // word stands for a whole frame, far longer than the system side needs to take it
  always_ff @(posedge shift_clk or negedge resetn_i)
  begin
    if (!resetn_i)
      word_r <= `SDL_CODE_RST;
    else if (word_end)
      word_r <= {shift_r[`SDL_CODE_W-2:0], serial_in_i};
  end

  // one toggle per word; only this single bit is synchronised to the system clock
  always_ff @(posedge shift_clk or negedge resetn_i)
  begin
    if (!resetn_i)
      word_tgl_r <= 1'b0;
    else if (word_end)
      word_tgl_r <= ~word_tgl_r;
  end

  // ----------------------------------------
  // system domain: pin synchronisers
  // ----------------------------------------
  logic [2:0] ld_sync_r;
  logic [2:0] clr_sync_r;
  logic [2:0] tgl_sync_r;
  sdl_pkg::sdl_ctrl_t ctrl_r;
  logic tgl_seen_r;

  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
      ld_sync_r <= 3'h7;
    else
      ld_sync_r <= {ld_sync_r[1:0], load_strobe_n_i};
  end

  // clear comes out of reset asserted, so the code stays zero until the pin is seen high
  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
      clr_sync_r <= 3'h0;
    else
      clr_sync_r <= {clr_sync_r[1:0], zero_clear_n_i};
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
      tgl_sync_r <= 3'h0;
    else
      tgl_sync_r <= {tgl_sync_r[1:0], word_tgl_r};
  end

  // ----------------------------------------
  // system domain: level filters
  // ----------------------------------------
  // a level counts once stages two and three agree; a one-cycle glitch is ignored
  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      ctrl_r.load_strobe_n <= 1'b1;
      ctrl_r.zero_clear_n <= 1'b0;
    end
    else
    begin
      if (ld_sync_r[1] == ld_sync_r[2])
        ctrl_r.load_strobe_n <= ld_sync_r[2];
      if (clr_sync_r[1] == clr_sync_r[2])
        ctrl_r.zero_clear_n <= clr_sync_r[2];
    end
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
      tgl_seen_r <= 1'b0;
    else if (tgl_sync_r[1] == tgl_sync_r[2])
      tgl_seen_r <= tgl_sync_r[2];
  end

  // ----------------------------------------
  // word crossing
  // ----------------------------------------
  // one-cycle strobe per settled toggle; word_r has stood still for many cycles by then
  logic word_evt;
  assign word_evt = (tgl_sync_r[1] == tgl_sync_r[2]) && (tgl_sync_r[2] != tgl_seen_r);

  // ----------------------------------------
  // word buffer
  // ----------------------------------------
  // host may shift words faster than they are used; buffer drains one word per cycle
  // except while clear is low, which stalls it and lets it fill
  sdl_pkg::sdl_code_t fifo_data;
  logic fifo_valid;
  logic fifo_wr_ready;
  logic drop_r;

  sdl_fifo #(
    .WIDTH(`SDL_CODE_W),
    .DEPTH(`SDL_FIFO_DEPTH)
  ) u_fifo (
    .clk_i(clk_sys_i),
    .resetn_i(resetn_i),
    .wr_data_i(word_r),
    .wr_valid_i(word_evt),
    .wr_ready_o(fifo_wr_ready),
    .rd_data_o(fifo_data),
    .rd_valid_o(fifo_valid),
    .rd_ready_i(ctrl_r.zero_clear_n)
  );

  // ----------------------------------------
  // shift image
  // ----------------------------------------
  // word last drained from the buffer as the shift register image
  sdl_pkg::sdl_code_t shift_img_r;
  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
      shift_img_r <= `SDL_CODE_RST;
    else if (fifo_valid && ctrl_r.zero_clear_n)
      shift_img_r <= fifo_data;
  end

  // ----------------------------------------
  // overflow flag
  // ----------------------------------------
  // a word that finds the buffer full is lost; sticky until reset
  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
      drop_r <= 1'b0;
    else if (word_evt && !fifo_wr_ready)
      drop_r <= 1'b1;
  end

  // ----------------------------------------
  // code register
  // ----------------------------------------
  // one-hot mode decoded from the filtered pins; clear wins over load
  typedef enum logic [2:0] {
    SDL_MODE_ZERO = 3'b001,
    SDL_MODE_HOLD = 3'b010,
    SDL_MODE_FOLLOW = 3'b100
  } sdl_mode_t;
  sdl_mode_t code_mode;
  sdl_pkg::sdl_code_t code_r;

  always_comb
  begin
    if (!ctrl_r.zero_clear_n)
      code_mode = SDL_MODE_ZERO;
    else if (!ctrl_r.load_strobe_n)
      code_mode = SDL_MODE_FOLLOW;
    else
      code_mode = SDL_MODE_HOLD;
  end

  // falling strobe and low level copy alike, so a load shorter than the
  // filter window is lost rather than half applied
  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
      code_r <= `SDL_CODE_RST;
    else
    begin
      unique case (code_mode)
        SDL_MODE_ZERO:
          code_r <= `SDL_CODE_RST;
        SDL_MODE_FOLLOW:
          code_r <= shift_img_r;
        SDL_MODE_HOLD:
          code_r <= code_r;
      endcase
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
      code_o <= `SDL_CODE_RST;
    else
      code_o <= code_r;
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
      shift_o <= `SDL_CODE_RST;
    else
      shift_o <= shift_img_r;
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
      overflow_o <= 1'b0;
    else
      overflow_o <= drop_r;
  end
endmodule : sdl_load_logic

// *** src/sdl_pkg.sv ***
package sdl_pkg;
  typedef logic [11:0] sdl_code_t;
  // pin levels after the three-stage filter
  typedef struct packed {
    logic load_strobe_n;
    logic zero_clear_n;
  } sdl_ctrl_t;
endpackage : sdl_pkg
